// [logic/nvmal_pkg.sv]
// shared constants, types and the word order of the configuration loader
package nvmal_pkg;

    // ----------------------------------------
    // eeprom word addresses
    // ----------------------------------------
    localparam int NVM_AW = 6;
    localparam logic [NVM_AW-1:0] W_SIZING = 6'h12;
    localparam logic [NVM_AW-1:0] W_ICW1 = 6'h0a;
    localparam logic [NVM_AW-1:0] W_SSID = 6'h0b;
    localparam logic [NVM_AW-1:0] W_SVID = 6'h0c;
    localparam logic [NVM_AW-1:0] W_DEVID0 = 6'h0d;
    localparam logic [NVM_AW-1:0] W_DUMMYID = 6'h1d;
    localparam logic [NVM_AW-1:0] W_DEVID1 = 6'h11;
    localparam logic [NVM_AW-1:0] W_SA0 = 6'h00;
    localparam logic [NVM_AW-1:0] W_SA1 = 6'h01;
    localparam logic [NVM_AW-1:0] W_SA2 = 6'h02;
    localparam logic [NVM_AW-1:0] W_PORT0 = 6'h20;
    localparam logic [NVM_AW-1:0] W_PORT1 = 6'h10;
    localparam logic [NVM_AW-1:0] W_TAIL = 6'h2e;

    // ----------------------------------------
    // load order
    // ----------------------------------------
    localparam logic [3:0] SEQ_LAST = 4'hc;
    localparam logic [3:0] IX_SIZING = 4'h0;
    localparam logic [3:0] IX_ICW1 = 4'h1;
    localparam logic [3:0] IX_SSID = 4'h2;
    localparam logic [3:0] IX_SVID = 4'h3;
    localparam logic [3:0] IX_DEVID0 = 4'h4;
    localparam logic [3:0] IX_DUMMYID = 4'h5;
    localparam logic [3:0] IX_DEVID1 = 4'h6;
    localparam logic [3:0] IX_SA0 = 4'h7;
    localparam logic [3:0] IX_SA1 = 4'h8;
    localparam logic [3:0] IX_SA2 = 4'h9;
    localparam logic [3:0] IX_PORT0 = 4'ha;
    localparam logic [3:0] IX_PORT1 = 4'hb;

    // ----------------------------------------
    // sizing word signature
    // ----------------------------------------
    localparam int SIG_HI = 15;
    localparam int SIG_LO = 14;
    localparam logic [1:0] SIG_VALID = 2'h1;

    // ----------------------------------------
    // init control word 1 fields
    // ----------------------------------------
    localparam int ICW_FORCE_SPEED = 11;
    localparam int ICW_DUPLEX = 10;
    localparam int ICW_LINK_RESET = 9;
    localparam int ICW_PIN_HOLD = 6;
    localparam int ICW_DEADLOCK = 5;
    localparam int ICW_LOS_INV = 4;
    localparam int ICW_PM_FULL = 3;
    localparam int ICW_LOAD_SS = 1;
    localparam int ICW_LOAD_DEV = 0;
    localparam logic [15:0] ICW1_USED = 16'h0e7b;
    localparam logic [15:0] ICW1_RST = 16'h0e2b;

    // ----------------------------------------
    // device control fields
    // ----------------------------------------
    localparam int CTRL_DUPLEX = 0;
    localparam int CTRL_LINK_RESET = 3;
    localparam int CTRL_LOS_INV = 7;
    localparam int CTRL_FORCE_SPEED = 11;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0889;
    localparam logic [31:0] CTRL_RST = 32'h0000_0809;

    // ----------------------------------------
    // station address
    // ----------------------------------------
    localparam int SA_PORT_BIT = 8;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SAL0 = 8'h08;
    localparam logic [7:0] OFS_SAH0 = 8'h0c;
    localparam logic [7:0] OFS_SAL1 = 8'h10;
    localparam logic [7:0] OFS_SAH1 = 8'h14;
    localparam logic [7:0] OFS_SUBSYS = 8'h18;
    localparam logic [7:0] OFS_DEVID = 8'h1c;
    localparam logic [7:0] OFS_DUMMYID = 8'h20;
    localparam logic [7:0] OFS_CTRL1 = 8'h24;
    localparam logic [7:0] OFS_ICW1 = 8'h28;

    // ----------------------------------------
    // status bits
    // ----------------------------------------
    localparam int ST_DONE = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_SIG_OK = 2;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam longint CLK_HZ = 25_000_000;
    localparam longint DEADLOCK_MS = 1000;
    localparam int DEADLOCK_CYCLES = int'((DEADLOCK_MS * CLK_HZ) / 1000);

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {RK_FULL, RK_PORT0, RK_PORT1} nvmal_kind_type;

    typedef struct packed {
        logic req;
        logic [NVM_AW-1:0] addr;
    } nvmal_req_type;

    typedef struct packed {
        logic ack;
        logic [15:0] data;
    } nvmal_rsp_type;

    // ----------------------------------------
    // control defaults from init word 1
    // ----------------------------------------
    function automatic logic [31:0] ctrl_from_icw1(input logic [31:0] c, input logic [15:0] w);
        logic [31:0] r;
        r = c;
        r[CTRL_FORCE_SPEED] = w[ICW_FORCE_SPEED];
        r[CTRL_DUPLEX] = w[ICW_DUPLEX];
        r[CTRL_LINK_RESET] = w[ICW_LINK_RESET];
        r[CTRL_LOS_INV] = w[ICW_LOS_INV];
        return r;
    endfunction

endpackage

// [logic/nvmal_seq.sv]
// word order table and per-reset selection of the loader
`timescale 1ns/1ps
module nvmal_seq
    import nvmal_pkg::*;
(
    // position
    input wire logic [3:0] idx,
    input wire nvmal_kind_type kind,
    // load options
    input wire logic load_ss,
    input wire logic load_dev,
    // result
    output logic [NVM_AW-1:0] word_addr,
    output logic use_word,
    output logic last
);

    // ----------------------------------------
    // address of each position
    // ----------------------------------------
    always_comb begin
        case (idx)
            IX_SIZING: word_addr = W_SIZING;
            IX_ICW1: word_addr = W_ICW1;
            IX_SSID: word_addr = W_SSID;
            IX_SVID: word_addr = W_SVID;
            IX_DEVID0: word_addr = W_DEVID0;
            IX_DUMMYID: word_addr = W_DUMMYID;
            IX_DEVID1: word_addr = W_DEVID1;
            IX_SA0: word_addr = W_SA0;
            IX_SA1: word_addr = W_SA1;
            IX_SA2: word_addr = W_SA2;
            IX_PORT0: word_addr = W_PORT0;
            IX_PORT1: word_addr = W_PORT1;
            default: word_addr = W_TAIL;
        endcase
    end

    // ----------------------------------------
    // which words this reset reads
    // ----------------------------------------
    always_comb begin
        case (idx)
            IX_SSID, IX_SVID: use_word = (kind == RK_FULL) && load_ss;
            IX_DEVID0, IX_DUMMYID, IX_DEVID1: use_word = (kind == RK_FULL) && load_dev;
            IX_PORT0: use_word = (kind != RK_PORT1);
            IX_PORT1: use_word = (kind != RK_PORT0);
            default: use_word = 1'b1;
        endcase
    end

    assign last = (idx == SEQ_LAST);

endmodule

// [logic/nvmal_top.sv]
// configuration loader: eeprom word fetch, default apply, apb view
`timescale 1ns/1ps
//----------------------------------------------------------------
// Functional notes
// - use loaded words only with valid signature
// - tail words chosen by reset type
// - first three words fill the address slot of each port being reset
// - second port gets address bit 40 inverted
// - init word bit 11 sets force speed
// - init word bit 10 sets duplex
// - init word bit 9 sets link reset
// - link reset zero starts auto-negotiation
// - bit 6 set keeps pins in idle
// - bit 6 clear floats pins with pull-ups
// - bit 5 enables one second grant revoke
// - init word bit 4 sets signal polarity
// - bit 3 clear: pm read-only, no D3
// - bit 3 set: full power management
// - bit 1 loads subsystem ids
// - bit 0 loads device ids
// - device ids per port and dummy
//----------------------------------------------------------------
module nvmal_top
    import nvmal_pkg::*;
#(
    parameter int DEADLOCK_CYC = DEADLOCK_CYCLES,
    parameter logic [15:0] DEF_SSID = 16'h0000, // arbitrary
    parameter logic [15:0] DEF_SVID = 16'h1234, // arbitrary
    parameter logic [15:0] DEF_DEVID = 16'h5678, // arbitrary
    parameter logic [15:0] DEF_DUMMYID = 16'h5679 // arbitrary
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // reset triggers
    input wire logic full_rst_req,
    input wire logic port0_rst_req,
    input wire logic port1_rst_req,
    // eeprom word port
    output nvmal_req_type nvm_req,
    input wire nvmal_rsp_type nvm_rsp,
    // eeprom arbiter watch
    input wire logic nvm_grant_active,
    input wire logic nvm_toggle,
    output logic nvm_revoke,
    // power and pins
    input wire logic low_leakage_idle,
    output logic pin_keep,
    output logic pin_float_pullup,
    output logic pm_regs_ro,
    output logic d3_allowed,
    // link side
    output logic an_start0,
    output logic an_start1,
    output logic [31:0] ctrl0_out,
    output logic [31:0] ctrl1_out,
    output logic load_done,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [1:0] {S_IDLE, S_STEP, S_WAIT, S_DONE} nvmal_state_type;

    nvmal_state_type state_r;
    nvmal_kind_type kind_r;
    nvmal_kind_type kind_nxt;
    logic [3:0] idx_r;
    nvmal_req_type req_r;
    logic done_r;
    logic sig_ok_r;
    logic [15:0] icw1_r;
    logic [15:0] sa0_r;
    logic [15:0] sa1_r;
    logic [15:0] ssid_r;
    logic [15:0] svid_r;
    logic [15:0] devid0_r;
    logic [15:0] devid1_r;
    logic [15:0] dummyid_r;
    logic [31:0] ctrl0_r;
    logic [31:0] ctrl1_r;
    logic [31:0] sal0_r;
    logic [31:0] sah0_r;
    logic [31:0] sal1_r;
    logic [31:0] sah1_r;
    logic an0_r;
    logic an1_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] wd_cnt_r;
    logic revoke_r;
    logic keep_r;
    logic float_r;
    logic pm_ro_r;
    logic d3_r;
    logic [NVM_AW-1:0] word_addr;
    logic use_word;
    logic last;
    logic start;
    logic take;
    logic tgt0;
    logic tgt1;
    logic [15:0] wd;
    logic apb_wr;
    logic [31:0] rd_mux;
    logic rd_hit;

    // ----------------------------------------
    // order table
    // ----------------------------------------
    nvmal_seq u_seq (
        .idx(idx_r),
        .kind(kind_r),
        .load_ss(icw1_r[ICW_LOAD_SS]),
        .load_dev(icw1_r[ICW_LOAD_DEV]),
        .word_addr(word_addr),
        .use_word(use_word),
        .last(last)
    );

    // ----------------------------------------
    // triggers
    // ----------------------------------------
    always_comb begin
        if (full_rst_req) begin
            kind_nxt = RK_FULL;
        end else if (port0_rst_req) begin
            kind_nxt = RK_PORT0;
        end else begin
            kind_nxt = RK_PORT1;
        end
    end

    assign start = full_rst_req || ((state_r == S_IDLE) && (port0_rst_req || port1_rst_req));
    assign take = (state_r == S_WAIT) && nvm_rsp.ack && !start;
    assign wd = nvm_rsp.data;
    assign tgt0 = (kind_r != RK_PORT1);
    assign tgt1 = (kind_r != RK_PORT0);

    // ----------------------------------------
    // load sequencer
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= S_IDLE;
            kind_r <= RK_FULL;
            idx_r <= 4'h0;
            req_r <= '0;
            done_r <= 1'b0;
        end else if (start) begin
            state_r <= S_STEP;
            kind_r <= kind_nxt;
            idx_r <= 4'h0;
            req_r <= '0;
            done_r <= 1'b0;
        end else begin
            case (state_r)
                S_STEP: begin
                    if (use_word) begin
                        req_r.req <= 1'b1;
                        req_r.addr <= word_addr;
                        state_r <= S_WAIT;
                    end else if (last) begin
                        state_r <= S_DONE;
                    end else begin
                        idx_r <= idx_r + 4'h1;
                    end
                end
                S_WAIT: begin
                    if (nvm_rsp.ack) begin
                        req_r.req <= 1'b0;
                        if (idx_r == IX_SIZING && wd[SIG_HI:SIG_LO] != SIG_VALID) begin
                            state_r <= S_DONE;
                        end else if (last) begin
                            state_r <= S_DONE;
                        end else begin
                            idx_r <= idx_r + 4'h1;
                            state_r <= S_STEP;
                        end
                    end
                end
                S_DONE: begin
                    done_r <= 1'b1;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // loaded words
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sig_ok_r <= 1'b0;
            icw1_r <= ICW1_RST;
            sa0_r <= 16'h0000;
            sa1_r <= 16'h0000;
            ssid_r <= DEF_SSID;
            svid_r <= DEF_SVID;
            devid0_r <= DEF_DEVID;
            devid1_r <= DEF_DEVID;
            dummyid_r <= DEF_DUMMYID;
        end else if (start) begin
            sig_ok_r <= 1'b0;
            icw1_r <= ICW1_RST;
            if (kind_nxt == RK_FULL) begin
                ssid_r <= DEF_SSID;
                svid_r <= DEF_SVID;
                devid0_r <= DEF_DEVID;
                devid1_r <= DEF_DEVID;
                dummyid_r <= DEF_DUMMYID;
            end
        end else if (take) begin
            case (idx_r)
                IX_SIZING: sig_ok_r <= (wd[SIG_HI:SIG_LO] == SIG_VALID);
                IX_ICW1: icw1_r <= (wd & ICW1_USED) | (ICW1_RST & ~ICW1_USED);
                IX_SSID: ssid_r <= wd;
                IX_SVID: svid_r <= wd;
                IX_DEVID0: devid0_r <= wd;
                IX_DUMMYID: dummyid_r <= wd;
                IX_DEVID1: devid1_r <= wd;
                IX_SA0: sa0_r <= wd;
                IX_SA1: sa1_r <= wd;
                default: sa1_r <= sa1_r;
            endcase
        end
    end

    // ----------------------------------------
    // per-port registers
    // ----------------------------------------
    assign apb_wr = psel && penable && pready_r && pwrite;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl0_r <= CTRL_RST;
            ctrl1_r <= CTRL_RST;
            sal0_r <= 32'h0000_0000;
            sah0_r <= 32'h0000_0000;
            sal1_r <= 32'h0000_0000;
            sah1_r <= 32'h0000_0000;
        end else if (start) begin
            if (kind_nxt != RK_PORT1) begin
                ctrl0_r <= CTRL_RST;
            end
            if (kind_nxt != RK_PORT0) begin
                ctrl1_r <= CTRL_RST;
            end
        end else if (take && idx_r == IX_ICW1) begin
            if (tgt0) begin
                ctrl0_r <= ctrl_from_icw1(ctrl0_r, wd);
            end
            if (tgt1) begin
                ctrl1_r <= ctrl_from_icw1(ctrl1_r, wd);
            end
        end else if (take && idx_r == IX_SA2) begin
            if (tgt0) begin
                sal0_r <= {sa1_r, sa0_r};
                sah0_r <= {16'h0000, wd};
            end
            if (tgt1) begin
                sal1_r <= {sa1_r, sa0_r};
                sah1_r <= {16'h0000, wd ^ (16'h0001 << SA_PORT_BIT)};
            end
        end else if (apb_wr) begin
            case (paddr)
                OFS_CTRL0: ctrl0_r <= pwdata & CTRL_MASK;
                OFS_CTRL1: ctrl1_r <= pwdata & CTRL_MASK;
                OFS_SAL0: sal0_r <= pwdata;
                OFS_SAH0: sah0_r <= {16'h0000, pwdata[15:0]};
                OFS_SAL1: sal1_r <= pwdata;
                OFS_SAH1: sah1_r <= {16'h0000, pwdata[15:0]};
                default: sal0_r <= sal0_r;
            endcase
        end
    end

    // ----------------------------------------
    // auto-negotiation start
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            an0_r <= 1'b0;
            an1_r <= 1'b0;
        end else begin
            an0_r <= (state_r == S_DONE) && !start && tgt0 && !ctrl0_r[CTRL_LINK_RESET];
            an1_r <= (state_r == S_DONE) && !start && tgt1 && !ctrl1_r[CTRL_LINK_RESET];
        end
    end

    // ----------------------------------------
    // pins and power management
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            keep_r <= 1'b0;
            float_r <= 1'b0;
            pm_ro_r <= 1'b0;
            d3_r <= 1'b1;
        end else begin
            keep_r <= low_leakage_idle && icw1_r[ICW_PIN_HOLD];
            float_r <= low_leakage_idle && !icw1_r[ICW_PIN_HOLD];
            pm_ro_r <= !icw1_r[ICW_PM_FULL];
            d3_r <= icw1_r[ICW_PM_FULL];
        end
    end

    // ----------------------------------------
    // grant watchdog
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wd_cnt_r <= 32'h0000_0000;
            revoke_r <= 1'b0;
        end else if (!icw1_r[ICW_DEADLOCK] || !nvm_grant_active || nvm_toggle) begin
            wd_cnt_r <= 32'h0000_0000;
            revoke_r <= 1'b0;
        end else if (wd_cnt_r >= 32'(DEADLOCK_CYC)) begin
            wd_cnt_r <= 32'h0000_0000;
            revoke_r <= 1'b1;
        end else begin
            wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
            revoke_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // apb read and answer
    // ----------------------------------------
    always_comb begin
        rd_hit = 1'b1;
        case (paddr)
            OFS_CTRL0: rd_mux = ctrl0_r;
            OFS_CTRL1: rd_mux = ctrl1_r;
            OFS_STATUS: rd_mux = {29'h0, sig_ok_r, (state_r != S_IDLE), done_r};
            OFS_SAL0: rd_mux = sal0_r;
            OFS_SAH0: rd_mux = sah0_r;
            OFS_SAL1: rd_mux = sal1_r;
            OFS_SAH1: rd_mux = sah1_r;
            OFS_SUBSYS: rd_mux = {ssid_r, svid_r};
            OFS_DEVID: rd_mux = {devid1_r, devid0_r};
            OFS_DUMMYID: rd_mux = {16'h0000, dummyid_r};
            OFS_ICW1: rd_mux = {16'h0000, icw1_r};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel && !penable;
            prdata_r <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
            pslverr_r <= psel && !penable && !rd_hit;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign nvm_req = req_r;
    assign nvm_revoke = revoke_r;
    assign pin_keep = keep_r;
    assign pin_float_pullup = float_r;
    assign pm_regs_ro = pm_ro_r;
    assign d3_allowed = d3_r;
    assign an_start0 = an0_r;
    assign an_start1 = an1_r;
    assign ctrl0_out = ctrl0_r;
    assign ctrl1_out = ctrl1_r;
    assign load_done = done_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

endmodule

// [tb/nvmal_properties.sv]
// assertion checker on the configuration loader ports
`timescale 1ns/1ps
module nvmal_properties
    import nvmal_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // loader
    input wire logic full_rst_req,
    input wire nvmal_req_type nvm_req,
    input wire nvmal_rsp_type nvm_rsp,
    input wire logic load_done,
    input wire logic an_start0,
    input wire logic [31:0] ctrl0_out,
    // arbiter and power
    input wire logic nvm_grant_active,
    input wire logic nvm_toggle,
    input wire logic nvm_revoke,
    input wire logic pin_keep,
    input wire logic pin_float_pullup,
    input wire logic pm_regs_ro,
    input wire logic d3_allowed
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    property p_start; full_rst_req |-> ##2 (nvm_req.req && nvm_req.addr == W_SIZING); endproperty
    a_start: assert property (p_start)
        else $error("sizing word not fetched first");
    property p_hold; nvm_req.req && !nvm_rsp.ack && !full_rst_req |=>
        nvm_req.req && $stable(nvm_req.addr); endproperty
    a_hold: assert property (p_hold)
        else $error("word request dropped early");
    property p_drop; nvm_req.req && nvm_rsp.ack |=> !nvm_req.req; endproperty
    a_drop: assert property (p_drop)
        else $error("word request held after ack");
    property p_done; $rose(load_done) |-> $past(nvm_rsp.ack, 2) || $past(nvm_rsp.ack, 3);
    endproperty
    a_done: assert property (p_done)
        else $error("done not after last word");
    property p_an; an_start0 |-> $rose(load_done) && !ctrl0_out[CTRL_LINK_RESET]; endproperty
    a_an: assert property (p_an)
        else $error("negotiation start unexpected");
    property p_excl; !(pin_keep && pin_float_pullup); endproperty
    a_excl: assert property (p_excl)
        else $error("pin keep and float together");
    property p_pm; pm_regs_ro != d3_allowed; endproperty
    a_pm: assert property (p_pm)
        else $error("power mode outputs disagree");
    property p_rev; nvm_revoke |-> $past(nvm_grant_active) && !$past(nvm_toggle); endproperty
    a_rev: assert property (p_rev)
        else $error("revoke without idle grant");
    c_done: cover property ($rose(load_done));
    c_an: cover property (an_start0);
    c_rev: cover property (nvm_revoke);
endmodule

bind nvmal_top nvmal_properties chk_u (.clk, .nrst, .full_rst_req, .nvm_req, .nvm_rsp,
    .load_done, .an_start0, .ctrl0_out, .nvm_grant_active, .nvm_toggle, .nvm_revoke,
    .pin_keep, .pin_float_pullup, .pm_regs_ro, .d3_allowed);

// [tb/nvmal_eeprom.sv]
// eeprom image model answering word requests
`timescale 1ns/1ps
module nvmal_eeprom
    import nvmal_pkg::*;
(
    // clock, reset and pacing
    input wire logic clk,
    input wire logic nrst,
    input wire logic slow,
    // word port
    input wire nvmal_req_type req,
    output nvmal_rsp_type rsp
);
    logic [15:0] mem [64]; // unique address per port and image
    logic [1:0] wait_r;
    always_ff @(posedge clk) begin
        rsp.ack <= 1'b0;
        rsp.data <= ~rsp.data;
        wait_r <= 2'h0;
        if (!nrst)
            rsp.data <= 16'h0;
        else if (req.req && !rsp.ack && wait_r != {slow, slow})
            wait_r <= wait_r + 2'h1;
        else if (req.req && !rsp.ack)
            rsp <= {1'b1, mem[req.addr]};
    end
endmodule

// [tb/tb_nvmal_top.sv]
// self-checking bench for the configuration loader
`timescale 1ns/1ps
module tb_nvmal_top
    import nvmal_pkg::*;
;
    localparam int DL = 20;
    logic clk = 1'b0, nrst = 1'b0, slow = 1'b0, low_leakage_idle = 1'b1;
    logic full_rst_req = 1'b0, port0_rst_req = 1'b0, port1_rst_req = 1'b0;
    logic nvm_grant_active = 1'b0, nvm_toggle = 1'b0, nvm_revoke, pin_keep, pin_float_pullup;
    logic pm_regs_ro, d3_allowed, an_start0, an_start1, load_done, pready, pslverr, err;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, ctrl0_out, ctrl1_out, q;
    logic [1:0] an_seen = 2'b00;
    logic [5:0] seen [$], exp_q [$];
    nvmal_req_type nvm_req;
    nvmal_rsp_type nvm_rsp;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    nvmal_top #(.DEADLOCK_CYC(DL)) dut_u (.clk, .nrst, .full_rst_req, .port0_rst_req,
        .port1_rst_req, .nvm_req, .nvm_rsp, .nvm_grant_active, .nvm_toggle, .nvm_revoke,
        .low_leakage_idle, .pin_keep, .pin_float_pullup, .pm_regs_ro, .d3_allowed, .an_start0,
        .an_start1, .ctrl0_out, .ctrl1_out, .load_done, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr);
    nvmal_eeprom eeprom_u (.clk, .nrst, .slow, .req(nvm_req), .rsp(nvm_rsp));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (nvm_req.req === 1'b1 && nvm_rsp.ack === 1'b1) seen.push_back(nvm_req.addr);
        if (an_start0 === 1'b1) an_seen[0] <= 1'b1;
        if (an_start1 === 1'b1) an_seen[1] <= 1'b1;
        if (cyc == 5000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic load(input logic [2:0] k);
        seen = {};
        an_seen = 2'b00;
        @(posedge clk);
        {port1_rst_req, port0_rst_req, full_rst_req} <= k;
        @(posedge clk);
        {port1_rst_req, port0_rst_req, full_rst_req} <= 3'b000;
        while (load_done !== 1'b0) @(posedge clk);
        while (load_done !== 1'b1) @(posedge clk);
    endtask
    task automatic ord();
        chk(32'(seen.size()), 32'(exp_q.size()));
        foreach (exp_q[i]) chk(32'(seen[i]), 32'(exp_q[i]));
    endtask
    initial begin
        int n;
        for (int i = 0; i < 64; i++) eeprom_u.mem[i] = 16'(i);
        eeprom_u.mem[W_SA0] = 16'h2211;
        eeprom_u.mem[W_SA1] = 16'h4433;
        eeprom_u.mem[W_SA2] = 16'h6655;
        eeprom_u.mem[W_ICW1] = 16'hf1f7;
        eeprom_u.mem[W_SIZING] = 16'h0000;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        chk(ctrl0_out, CTRL_RST);
        load(3'b001);
        exp_q = {W_SIZING};
        ord();
        rd(OFS_CTRL0, CTRL_RST);
        rd(OFS_STATUS, 32'h1);
        eeprom_u.mem[W_SIZING] = {SIG_VALID, 14'h0};
        load(3'b001);
        exp_q = {W_SIZING, W_ICW1, W_SSID, W_SVID, W_DEVID0, W_DUMMYID, W_DEVID1, W_SA0, W_SA1,
            W_SA2, W_PORT0, W_PORT1, W_TAIL};
        ord();
        rd(OFS_CTRL0, 32'h80);
        rd(OFS_CTRL1, 32'h80);
        rd(OFS_SAL0, 32'h44332211);
        rd(OFS_SAH0, 32'h6655);
        rd(OFS_SAL1, 32'h44332211);
        rd(OFS_SAH1, 32'h6755);
        rd(OFS_SUBSYS, 32'h000b000c);
        rd(OFS_DEVID, 32'h0011000d);
        rd(OFS_DUMMYID, 32'h1d);
        rd(OFS_ICW1, 32'h73);
        rd(OFS_STATUS, 32'h5);
        chk({30'h0, an_seen}, 32'h3);
        chk({29'h0, pin_keep, pm_regs_ro, d3_allowed}, 32'h6);
        nvm_grant_active <= 1'b1;
        n = 0;
        while (nvm_revoke !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, n >= DL + 1 && n <= DL + 4}, 32'h1);
        nvm_grant_active <= 1'b0;
        eeprom_u.mem[W_ICW1] = 16'h0e08;
        slow <= 1'b1;
        load(3'b100);
        exp_q = {W_SIZING, W_ICW1, W_SA0, W_SA1, W_SA2, W_PORT1, W_TAIL};
        ord();
        rd(OFS_CTRL1, CTRL_RST);
        rd(OFS_CTRL0, 32'h80);
        chk({29'h0, pin_float_pullup, pm_regs_ro, d3_allowed}, 32'h5);
        chk({30'h0, an_seen}, 32'h0);
        slow <= 1'b0;
        load(3'b010);
        exp_q = {W_SIZING, W_ICW1, W_SA0, W_SA1, W_SA2, W_PORT0, W_TAIL};
        ord();
        rd(OFS_CTRL0, CTRL_RST);
        rd(OFS_SAH0, 32'h6655);
        load(3'b001);
        exp_q = {W_SIZING, W_ICW1, W_SA0, W_SA1, W_SA2, W_PORT0, W_PORT1, W_TAIL};
        ord();
        low_leakage_idle <= 1'b0;
        apb(1'b1, OFS_CTRL1, 32'hffff_ffff);
        chk({30'h0, pin_keep, pin_float_pullup}, 32'h0);
        apb(1'b0, 8'hfc, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(ctrl1_out, CTRL_MASK);
        print_verdict();
    end
endmodule
